//--- verification/bus_peer_model.sv
`timescale 1ns/1ns
`default_nettype none

module bus_peer_model (
  output logic      serialBusClock,
  output logic      peerPull_n,
  input  wire logic dataLine
);
  logic [31:0] rxShift;

  // link clock rests high outside frames, line released
  initial begin
    serialBusClock = 1'b1;
    peerPull_n     = 1'b1;
    rxShift        = 32'h00000000;
  end

  // one 80 ns period; the pull holds for the whole state entered
  task automatic tick(input logic pull);
    serialBusClock = 1'b0;
    rxShift = {rxShift[30:0], dataLine};
    #40;
    serialBusClock = 1'b1;
    peerPull_n = ~pull;
    #40;
  endtask : tick
endmodule : bus_peer_model

`default_nettype wire

//--- verification/serial_bus_message_transfer_test.sv
`timescale 1ns/1ns
`default_nettype none

module serial_bus_message_transfer_test
  import serial_bus_pkg::*;
;
  logic       core_clk, reset_n, regWrite, regRead, serialBusClock;
  logic       dataLineOut, dataLineOe_n, peerPull_n, dataLine;
  logic       chainIn, chainOut, serialBusInterrupt;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, seen;
  int         bad_count, cmp_count;

  // pulled-up wire: any party pulling low wins
  assign dataLine = (dataLineOe_n ? 1'b1 : dataLineOut) & peerPull_n;

  serial_bus_message_transfer dut (
    .core_clk           (core_clk),
    .reset_n            (reset_n),
    .regAddr            (regAddr),
    .regWrData          (regWrData),
    .regWrite           (regWrite),
    .regRead            (regRead),
    .regRdData          (regRdData),
    .serialBusClock     (serialBusClock),
    .dataLineIn         (dataLine),
    .dataLineOut        (dataLineOut),
    .dataLineOe_n       (dataLineOe_n),
    .chainIn            (chainIn),
    .chainOut           (chainOut),
    .serialBusInterrupt (serialBusInterrupt)
  );
  bus_peer_model peer (
    .serialBusClock (serialBusClock),
    .peerPull_n     (peerPull_n),
    .dataLine       (dataLine)
  );

  // 125 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask : check1

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge core_clk);
    regWrite  <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    seen = regRdData;
  endtask : rd

  task automatic expect_reg(input logic [2:0] a, input logic [7:0] exp);
    rd(a);
    check({24'h0, seen}, {24'h0, exp});
  endtask : expect_reg

  // start on the falling edge so link edges never race the sampler
  task automatic step(input logic pull);
    @(negedge core_clk);
    peer.tick(pull);
  endtask : step

  // local node wins the bus and sends msg; peer acks when ack is set
  task automatic send_frame(input logic [31:0] msg, input logic ack);
    wr(OFS_CONTROL, 8'h01);
    repeat (4) @(negedge core_clk);
    check1(dataLineOe_n, 1'b0);
    step(1'b0);
    expect_reg(OFS_STATE, S_ARB);
    check1(chainOut, 1'b0);
    step(1'b0);
    rd(OFS_CONTROL);
    check1(seen[BIT_MASTERY_WON], 1'b1);
    check1(seen[BIT_READ_PENDING], 1'b0);
    check1(seen[BIT_NO_ACK], 1'b0);
    check1(serialBusInterrupt, 1'b1);
    for (int i = 3; i > 0; i--) begin
      wr(3'(i), msg[8*i +: 8]);
    end
    wr(OFS_CONTROL, 8'h01); // drop mastery won, keep the request
    expect_reg(OFS_STATE, S_LOAD);
    wr(OFS_SHIFT_BYTE_0, msg[7:0]);
    repeat (2) @(negedge core_clk);
    check1(dataLineOe_n, 1'b0);
    rd(OFS_CONTROL);
    check1(seen[BIT_WRITE_PENDING], 1'b0);
    for (int i = 31; i >= 0; i--) begin
      step(1'b0);
      check1(dataLine, msg[i]);
    end
    step(1'b0);
    check(peer.rxShift, msg);
    expect_reg(OFS_STATE, S_PREACK);
    check1(dataLine, 1'b1);
    step(ack);
    expect_reg(OFS_STATE, S_ACK);
    step(1'b0);
    check1(dataLine, 1'b1);
    rd(OFS_CONTROL);
    check1(seen[BIT_NO_ACK], ~ack);
    check1(serialBusInterrupt, ~ack);
    expect_reg(OFS_STATE, S_DONE);
    step(1'b0);
    repeat (20) @(negedge core_clk);
    expect_reg(OFS_STATE, S_IDLE);
    check1(dataLineOe_n, 1'b1);
    for (int i = 0; i < 4; i++) begin
      expect_reg(3'(i), msg[8*i +: 8]);
    end
  endtask : send_frame

  // peer sends msg to this node; deaf means an unread message is pending
  task automatic peer_frame(input logic [31:0] msg, input logic deaf);
    @(posedge core_clk);
    chainIn <= 1'b0;
    step(1'b0);
    check1(chainOut, ~deaf);
    step(1'b1);
    for (int i = 31; i >= 0; i--) begin
      step(~msg[i]);
    end
    step(1'b0);
    step(1'b0);
    check1(dataLineOe_n, deaf);
    step(1'b0);
    rd(OFS_CONTROL);
    check1(seen[BIT_READ_PENDING], 1'b1);
    check1(seen[BIT_DEAF], deaf);
    check1(serialBusInterrupt, 1'b1);
    step(1'b0);
    @(posedge core_clk);
    chainIn <= 1'b1;
  endtask : peer_frame

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // main sequence: send, receive twice (second deaf), drain, send unacked
  initial begin
    bad_count = 0;
    cmp_count = 0;
    reset_n   = 1'b0;
    regAddr   = 3'h0;
    regWrData = 8'h00;
    regWrite  = 1'b0;
    regRead   = 1'b0;
    chainIn   = 1'b1;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    expect_reg(OFS_STATE, S_IDLE);
    expect_reg(OFS_CONTROL, RST_BYTE);
    expect_reg(3'h7, 8'h00);
    check1(dataLineOut, 1'b0);
    wr(OFS_NODE_ADDRESS, 8'h05);
    expect_reg(OFS_NODE_ADDRESS, 8'h05);
    send_frame(32'h2468ace1, 1'b1);
    peer_frame(32'hb1e2d3c4, 1'b0);
    peer_frame(32'ha5f00f5a, 1'b1);
    for (int i = 0; i < 4; i++) begin
      expect_reg(3'(i), 8'(32'hb1e2d3c4 >> (8 * i)));
    end
    rd(OFS_CONTROL);
    check1(seen[BIT_READ_PENDING], 1'b0);
    check1(serialBusInterrupt, 1'b0);
    send_frame(32'h9b3c5a70, 1'b0);
    wr(OFS_CONTROL, 8'h00);
    repeat (2) @(negedge core_clk);
    check1(serialBusInterrupt, 1'b0);
    // software names this node prior master while idle
    wr(OFS_CONTROL, 8'h04);
    expect_reg(OFS_CONTROL, 8'h06);
    check1(chainOut, 1'b1);
    stop_test();
  end
endmodule : serial_bus_message_transfer_test

`default_nettype wire

//--- verilog/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1;

  // two flops; the first is read by the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '1;
      synced <= '1;
    end else begin
      stage1 <= async;
      synced <= stage1;
    end
  end

endmodule : pin_sync

`default_nettype wire

//--- verilog/serial_bus_message_transfer.sv
//
// Functional notes
// R1: read pending at state 3 entry sets deaf
// R2: master drives shift output in states 3-34
// R3: non-deaf nodes shift on rising clock edges
// R4: one-hot readable state, advance per clock
// R5: master releases data line in state 35
// R6: addressed non-deaf node pulls low in 36
// R7: master samples ack into no-ack flag
// R8: addressed node sets read pending in 37
// R9: master releases line in 37, back to 0
// R10: read of shift byte 3 clears read pending
// R11: write of shift byte 0 starts sending
// R12: 32 bits, change on rise, latch on fall
// R13: begin low from load until first bit
// R14: write pending pulls line low in idle
// R15: chain token arbitration picks next master
// R16: processor loads shift byte 0 last
// R17: idle in state 0 until new request
// R18: winner sets mastery won on load state
// R19: processor checks flags before loading
// R20: line driven only as wired-AND pull-down
`timescale 1ns/1ns
`default_nettype none

module serial_bus_message_transfer
  import serial_bus_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       serialBusClock,
  input  wire logic       dataLineIn,
  output logic            dataLineOut,
  output logic            dataLineOe_n,
  input  wire logic       chainIn,
  output logic            chainOut,
  output logic            serialBusInterrupt
);

  bus_state_t  state;
  logic [31:0] shiftReg;
  logic [4:0]  bitCount;
  logic        sampledBit;
  logic [2:0]  nodeAddress;
  logic        writePending;
  logic        isMaster;
  logic        priorMaster;
  logic        noAck;
  logic        readPending;
  logic        deaf;
  logic        masteryWon;
  logic [2:0]  syncIn;
  logic        clkSync;
  logic        dataSync;
  logic        chainSync;
  logic        clkLast;
  logic        clockRise;
  logic        clockFall;
  logic        addressed;
  logic        becomeMaster;
  logic        pullLow;
  logic        readShift3;
  logic        writeShift0;
  logic        setReadPending;

  // all link inputs come from another clock domain
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk    (core_clk),
    .rst_n  (reset_n),
    .async  ({serialBusClock, dataLineIn, chainIn}),
    .synced (syncIn)
  );

  assign clkSync   = syncIn[2];
  assign dataSync  = syncIn[1];
  assign chainSync = syncIn[0];

  // edge finder on the synchronised link clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkLast <= 1'b1;
    end else begin
      clkLast <= clkSync;
    end
  end

  assign clockRise = clkSync && !clkLast;
  assign clockFall = !clkSync && clkLast;

  // decode helpers
  assign readShift3  = regRead && (regAddr == OFS_SHIFT_BYTE_3);
  assign writeShift0 = regWrite && (regAddr == OFS_SHIFT_BYTE_0);
  assign addressed   = !deaf && (shiftReg[ADDR_TOP:ADDR_BOTTOM] == nodeAddress); // R6
  assign becomeMaster = chainSync && writePending && !priorMaster; // R15
  assign setReadPending = clockRise && (state == S_ACK) && addressed; // R8

  // state counter, one step per link clock rise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= S_IDLE;
      bitCount <= 5'h00;
    end else if (clockRise) begin // R4
      case (state)
        // clock only restarts when somebody requests
        S_IDLE:   state <= S_ARB; // R17
        S_ARB:    state <= S_LOAD;
        S_LOAD:   state <= S_DATA;
        S_DATA: begin
          if (bitCount == LAST_DATA_BIT) begin // R12
            state    <= S_PREACK;
            bitCount <= 5'h00;
          end else begin
            bitCount <= bitCount + 5'h01;
          end
        end
        S_PREACK: state <= S_ACK;
        S_ACK:    state <= S_DONE;
        S_DONE:   state <= S_IDLE; // R9
        default:  state <= S_IDLE;
      endcase
    end
  end

  // receive bit is caught on the falling link edge
  // the ack state is sampled mid-state too: an ack may drop with the clock rise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sampledBit <= 1'b1;
    end else if (clockFall && (state == S_DATA || state == S_ACK)) begin
      sampledBit <= dataSync; // R12 R7
    end
  end

  // shift register: local byte writes, bus shifts
  // bytes are locked out while bits are on the wire
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg <= RST_SHIFT;
    end else if (state == S_DATA) begin
      if (clockRise && !deaf) begin
        shiftReg <= {shiftReg[30:0], sampledBit}; // R3
      end
    end else if (regWrite) begin
      case (regAddr)
        OFS_SHIFT_BYTE_0: shiftReg[7:0]   <= regWrData;
        OFS_SHIFT_BYTE_1: shiftReg[15:8]  <= regWrData;
        OFS_SHIFT_BYTE_2: shiftReg[23:16] <= regWrData;
        OFS_SHIFT_BYTE_3: shiftReg[31:24] <= regWrData;
        default: ;
      endcase
    end
  end

  // node address register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      nodeAddress <= RST_ADDRESS;
    end else if (regWrite && regAddr == OFS_NODE_ADDRESS) begin
      nodeAddress <= regWrData[2:0];
    end
  end

  // write pending: set by software, cleared by loading byte 0
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      writePending <= 1'b0;
    end else if (writeShift0 && state == S_LOAD && isMaster) begin
      writePending <= 1'b0; // R11
    end else if (regWrite && regAddr == OFS_CONTROL) begin
      writePending <= regWrData[BIT_WRITE_PENDING];
    end
  end

  // mastery tracking and arbitration
  // software may name the first prior master at start-up
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      isMaster    <= 1'b0;
      priorMaster <= 1'b0;
    end else if (clockRise && state == S_IDLE) begin
      priorMaster <= isMaster; // R15
    end else if (clockRise && state == S_ARB) begin
      isMaster <= becomeMaster; // R15
    end else if (regWrite && regAddr == OFS_CONTROL && state == S_IDLE) begin
      priorMaster <= regWrData[BIT_PRIOR_MASTER];
      isMaster    <= regWrData[BIT_PRIOR_MASTER];
    end
  end

  // mastery won: hardware set beats software clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      masteryWon <= 1'b0;
    end else if (clockRise && state == S_ARB && becomeMaster) begin
      masteryWon <= 1'b1; // R18
    end else if (regWrite && regAddr == OFS_CONTROL && !regWrData[BIT_MASTERY_WON]) begin
      masteryWon <= 1'b0;
    end
  end

  // no-ack: level seen mid state 36, taken on leaving it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      noAck <= 1'b0;
    end else if (clockRise && state == S_ACK && isMaster) begin
      noAck <= sampledBit; // R7
    end else if (regWrite && regAddr == OFS_CONTROL && !regWrData[BIT_NO_ACK]) begin
      noAck <= 1'b0;
    end
  end

  // read pending: set wins over the clearing read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readPending <= 1'b0;
    end else if (setReadPending) begin
      readPending <= 1'b1; // R8
    end else if (readShift3) begin
      readPending <= 1'b0; // R10
    end
  end

  // deaf follows read pending at entry to state 3
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      deaf <= 1'b0;
    end else if (clockRise && state == S_LOAD) begin
      deaf <= readPending; // R1
    end
  end

  // data line pull-down decision per state
  always_comb begin
    pullLow = 1'b0;
    case (state)
      S_IDLE:   pullLow = writePending; // R14
      // begin-low: held from load until first bit
      S_LOAD:   pullLow = isMaster && !writePending; // R13
      S_DATA:   pullLow = isMaster && !shiftReg[31]; // R2
      S_PREACK: pullLow = 1'b0; // R5
      S_ACK:    pullLow = addressed; // R6
      S_DONE:   pullLow = 1'b0; // R9
      default:  pullLow = 1'b0;
    endcase
  end

  // open-drain line: only ever low or released
  assign dataLineOut = 1'b0; // R20

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dataLineOe_n <= 1'b1;
      chainOut     <= 1'b0;
    end else begin
      dataLineOe_n <= !pullLow; // R20
      chainOut     <= priorMaster || (chainSync && !writePending); // R15
    end
  end

  assign serialBusInterrupt = noAck || readPending || masteryWon;

  // read data stands in the cycle after the strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= RST_BYTE;
    end else if (regRead) begin
      case (regAddr)
        OFS_SHIFT_BYTE_0: regRdData <= shiftReg[7:0];
        OFS_SHIFT_BYTE_1: regRdData <= shiftReg[15:8];
        OFS_SHIFT_BYTE_2: regRdData <= shiftReg[23:16];
        OFS_SHIFT_BYTE_3: regRdData <= shiftReg[31:24];
        OFS_CONTROL: begin
          regRdData                    <= RST_BYTE;
          regRdData[BIT_WRITE_PENDING] <= writePending;
          regRdData[BIT_MASTER_STATUS] <= isMaster;
          regRdData[BIT_PRIOR_MASTER]  <= priorMaster;
          regRdData[BIT_NO_ACK]        <= noAck;
          regRdData[BIT_READ_PENDING]  <= readPending;
          regRdData[BIT_DEAF]          <= deaf;
          regRdData[BIT_MASTERY_WON]   <= masteryWon;
        end
        OFS_NODE_ADDRESS: regRdData <= {5'h00, nodeAddress};
        OFS_STATE:        regRdData <= state; // R4
        default:          regRdData <= RST_BYTE;
      endcase
    end else begin
      regRdData <= RST_BYTE;
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_state_onehot: assert property ( // R4
    $onehot(state)
  ) else $error("state code is not one-hot");

  a_idle_request: assert property ( // R14
    (state == S_IDLE && writePending) |=> !dataLineOe_n
  ) else $error("idle request did not pull the line low");

  a_deaf_capture: assert property ( // R1
    (clockRise && state == S_LOAD) |=> (deaf == $past(readPending)) && state == S_DATA
  ) else $error("deaf flag not taken at state 3 entry");

  a_ack_drive: assert property ( // R6
    (state == S_ACK && addressed) |=> !dataLineOe_n
  ) else $error("addressed node did not acknowledge");

  a_noack_sample: assert property ( // R7
    (clockRise && state == S_ACK && isMaster) |=> noAck == $past(sampledBit)
  ) else $error("no-ack flag does not match sampled line");

  a_read_clear: assert property ( // R10
    (readShift3 && !setReadPending) |=> !readPending
  ) else $error("read of shift byte 3 did not clear read pending");

  a_load_start: assert property ( // R11
    (writeShift0 && state == S_LOAD && isMaster) |=> !writePending ##1 !dataLineOe_n
  ) else $error("byte 0 load did not start the frame");

  a_data_length: assert property ( // R12
    (clockRise && state == S_DATA && bitCount == LAST_DATA_BIT) |=> state == S_PREACK
  ) else $error("data phase length wrong");

  a_done_return: assert property ( // R9
    (clockRise && state == S_DONE) |=> state == S_IDLE ##1 !(state == S_DONE)
  ) else $error("state 37 did not return to idle");

  a_master_release: assert property ( // R5
    (state == S_PREACK) ##1 (state == S_PREACK) |-> dataLineOe_n
  ) else $error("line not released in state 35");

  a_chain_prior: assert property ( // R15
    priorMaster |=> chainOut
  ) else $error("prior master did not raise chain out");

  a_mastery_won: assert property ( // R18
    (clockRise && state == S_ARB && becomeMaster) |=> masteryWon && isMaster && state == S_LOAD
  ) else $error("mastery won not flagged");

endmodule : serial_bus_message_transfer

`default_nettype wire

//--- verilog/serial_bus_pkg.sv
package serial_bus_pkg;

  // register offsets on the local port
  localparam logic [2:0] OFS_SHIFT_BYTE_0 = 3'h0;
  localparam logic [2:0] OFS_SHIFT_BYTE_1 = 3'h1;
  localparam logic [2:0] OFS_SHIFT_BYTE_2 = 3'h2;
  localparam logic [2:0] OFS_SHIFT_BYTE_3 = 3'h3;
  localparam logic [2:0] OFS_CONTROL      = 3'h4;
  localparam logic [2:0] OFS_NODE_ADDRESS = 3'h5;
  localparam logic [2:0] OFS_STATE        = 3'h6;

  // control and status bit positions
  localparam int BIT_WRITE_PENDING = 0;
  localparam int BIT_MASTER_STATUS = 1;
  localparam int BIT_PRIOR_MASTER  = 2;
  localparam int BIT_NO_ACK        = 3;
  localparam int BIT_READ_PENDING  = 4;
  localparam int BIT_DEAF          = 5;
  localparam int BIT_MASTERY_WON   = 7;

  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [31:0] RST_SHIFT   = 32'h00000000;
  localparam logic [2:0]  RST_ADDRESS = 3'h0;

  // message layout
  localparam int         MSG_BITS      = 32;
  localparam int         ADDR_TOP      = 31;
  localparam int         ADDR_BOTTOM   = 29;
  localparam logic [4:0] LAST_DATA_BIT = 5'h1f;

  // one-hot readable state codes
  typedef enum logic [7:0] {
    S_IDLE   = 8'h01,
    S_ARB    = 8'h02,
    S_LOAD   = 8'h04,
    S_DATA   = 8'h08,
    S_PREACK = 8'h10,
    S_ACK    = 8'h20,
    S_DONE   = 8'h40
  } bus_state_t;

endpackage : serial_bus_pkg
